// ==== common/card_host_consts.vh ====
// Constants for the card bus host controller.
`ifndef CARD_HOST_CONSTS_VH
`define CARD_HOST_CONSTS_VH
`define SYS_CLK_NS        50
`define INIT_TIME_NS      1000000
`define INIT_CLOCKS       74
`define CLK_DIV_HALF      4'h4
`define WIDTH_1           2'h0
`define WIDTH_4           2'h1
`define WIDTH_8           2'h2
`define CMD_BITS          6'h30
`endif

// ==== hdl/card_host.v ====
// Host controller that drives a managed flash card over clock, command and data lines.
`timescale 1ns/1ns
`include "card_host_consts.vh"
module card_host #(
    parameter INIT_CYCLES = (`INIT_TIME_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS
) (
    input  wire        sys_clk_in,
    input  wire        rst_in,
    input  wire        supply_ok_in,
    input  wire        boot_hold_in,
    input  wire        cmd_valid_in,
    input  wire [47:0] cmd_frame_in,
    input  wire        cmd_push_pull_in,
    input  wire [1:0]  bus_width_in,
    input  wire        tx_valid_in,
    input  wire [7:0]  tx_byte_in,
    input  wire        rx_ready_in,
    input  wire        cmd_line_in,
    input  wire [7:0]  dat_line_in,
    output reg         init_done_out,
    output reg         cmd_ready_out,
    output reg         tx_ready_out,
    output reg         rx_valid_out,
    output reg  [7:0]  rx_byte_out,
    output reg         bus_clk_out,
    output reg         cmd_line_out,
    output reg         cmd_oe_out,
    output reg  [7:0]  dat_line_out,
    output reg  [7:0]  dat_oe_out
);
    localparam ST_POWER = 3'h0;
    localparam ST_ONES  = 3'h1;
    localparam ST_IDLE  = 3'h2;
    localparam ST_CMD   = 3'h3;
    localparam ST_BOOT  = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    reg        cmd_s1;
    reg        cmd_s2;
    reg [7:0]  dat_s1;
    reg [7:0]  dat_s2;
    reg        sup_s1;
    reg        sup_s2;
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_s1 <= 1'b1;
            cmd_s2 <= 1'b1;
            dat_s1 <= 8'hff;
            dat_s2 <= 8'hff;
            sup_s1 <= 1'b0;
            sup_s2 <= 1'b0;
        end else begin
            cmd_s1 <= cmd_line_in;
            cmd_s2 <= cmd_s1;
            dat_s1 <= dat_line_in;
            dat_s2 <= dat_s1;
            sup_s1 <= supply_ok_in;
            sup_s2 <= sup_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus clock is divided down; rise_now marks the cycle that raises it.
    reg  [3:0] div;
    wire       edge_now = (div == `CLK_DIV_HALF - 4'h1);
    wire       rise_now = edge_now && !bus_clk_out;
    wire       fall_now = edge_now && bus_clk_out;
    reg        clk_run;
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div         <= 4'h0;
            bus_clk_out <= 1'b0;
        end else if (!clk_run) begin
            div         <= 4'h0;
            bus_clk_out <= 1'b0;
        end else if (edge_now) begin
            div         <= 4'h0;
            bus_clk_out <= !bus_clk_out;
        end else begin
            div <= div + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    reg [2:0]  state;
    reg [31:0] wait_cnt;
    reg [6:0]  clk_cnt;
    reg [47:0] shift;
    reg [5:0]  bit_cnt;
    reg        od_mode;
    reg [1:0]  width;
    reg [7:0]  rx_sh;
    reg [3:0]  rx_cnt;
    reg [7:0]  tx_sh;
    reg [3:0]  tx_cnt;
    reg        tx_busy;
    // Two-entry buffer between the incoming data lines and the user.
    reg [7:0]  buf_mem [0:1];
    reg        wr_ptr;
    reg        rd_ptr;
    reg [1:0]  count;
    wire       buf_full = (count == 2'h2);
    wire       rx_word = (state == ST_BOOT) && fall_now && (rx_cnt == 4'h7);
    wire       buf_push = rx_word && !buf_full;
    wire       buf_pop = rx_valid_out && rx_ready_in;
    wire [3:0] step = (width == `WIDTH_8) ? 4'h8 : (width == `WIDTH_4) ? 4'h4 : 4'h1;

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state         <= ST_POWER;
            wait_cnt      <= 32'h0000_0000;
            clk_cnt       <= 7'h00;
            shift         <= 48'h0000_0000_0000;
            bit_cnt       <= 6'h00;
            od_mode       <= 1'b1;
            width         <= `WIDTH_1;
            clk_run       <= 1'b0;
            init_done_out <= 1'b0;
            cmd_ready_out <= 1'b0;
            cmd_line_out  <= 1'b1;
            cmd_oe_out    <= 1'b0;
            rx_sh         <= 8'h00;
            rx_cnt        <= 4'h0;
        end else begin
            case (state)
                ST_POWER: begin
                    if (sup_s2) begin
                        state   <= ST_ONES;
                        clk_run <= 1'b1;
                    end
                end
                ST_ONES: begin
                    cmd_oe_out <= boot_hold_in;
                    cmd_line_out <= !boot_hold_in;
                    if (wait_cnt < INIT_CYCLES)
                        wait_cnt <= wait_cnt + 32'h0000_0001;
                    if (rise_now && clk_cnt < `INIT_CLOCKS)
                        clk_cnt <= clk_cnt + 7'h01;
                    if (wait_cnt >= INIT_CYCLES && clk_cnt >= `INIT_CLOCKS) begin
                        init_done_out <= 1'b1;
                        if (boot_hold_in) begin
                            state  <= ST_BOOT;
                            rx_cnt <= 4'h0;
                        end else begin
                            state         <= ST_IDLE;
                            cmd_ready_out <= 1'b1;
                            cmd_oe_out    <= 1'b0;
                            cmd_line_out  <= 1'b1;
                        end
                    end
                end
                ST_IDLE: begin
                    width <= (bus_width_in == `WIDTH_8) ? `WIDTH_8 :
                             (bus_width_in == `WIDTH_4) ? `WIDTH_4 : `WIDTH_1;
                    if (cmd_valid_in) begin
                        shift         <= cmd_frame_in;
                        od_mode       <= !cmd_push_pull_in;
                        bit_cnt       <= 6'h00;
                        cmd_ready_out <= 1'b0;
                        state         <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (fall_now) begin
                        if (bit_cnt == `CMD_BITS) begin
                            cmd_oe_out    <= 1'b0;
                            cmd_line_out  <= 1'b1;
                            cmd_ready_out <= 1'b1;
                            state         <= ST_IDLE;
                        end else begin
                            cmd_line_out <= shift[47];
                            cmd_oe_out   <= od_mode ? !shift[47] : 1'b1;
                            shift        <= {shift[46:0], 1'b1};
                            bit_cnt      <= bit_cnt + 6'h01;
                        end
                    end
                end
                ST_BOOT: begin
                    if (fall_now) begin
                        rx_sh  <= {rx_sh[6:0], dat_s2[0]};
                        rx_cnt <= (rx_cnt == 4'h7) ? 4'h0 : rx_cnt + 4'h1;
                    end
                    if (!boot_hold_in) begin
                        cmd_oe_out    <= 1'b0;
                        cmd_line_out  <= 1'b1;
                        cmd_ready_out <= 1'b1;
                        state         <= ST_IDLE;
                    end
                end
                default: state <= ST_POWER;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // A full buffer drops further boot bytes; boot data cannot be paused.
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr       <= 1'b0;
            rd_ptr       <= 1'b0;
            count        <= 2'h0;
            rx_valid_out <= 1'b0;
            rx_byte_out  <= 8'h00;
            buf_mem[0]   <= 8'h00;
            buf_mem[1]   <= 8'h00;
        end else begin
            if (buf_push) begin
                buf_mem[wr_ptr] <= {rx_sh[6:0], dat_s2[0]};
                wr_ptr          <= !wr_ptr;
            end
            if (buf_pop)
                rd_ptr <= !rd_ptr;
            count        <= count + {1'b0, buf_push} - {1'b0, buf_pop};
            rx_valid_out <= (count + {1'b0, buf_push} - {1'b0, buf_pop}) != 2'h0;
            rx_byte_out  <= buf_mem[buf_pop ? !rd_ptr : rd_ptr];
            if (count == 2'h0 && buf_push)
                rx_byte_out <= {rx_sh[6:0], dat_s2[0]};
            else if (count == 2'h1 && buf_push && buf_pop)
                rx_byte_out <= {rx_sh[6:0], dat_s2[0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: bytes leave on the active lines, high bits first per step.
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_sh        <= 8'h00;
            tx_cnt       <= 4'h0;
            tx_busy      <= 1'b0;
            tx_ready_out <= 1'b0;
            dat_line_out <= 8'hff;
            dat_oe_out   <= 8'h00;
        end else begin
            tx_ready_out <= (state == ST_IDLE) && !tx_busy && !tx_valid_in;
            if (!tx_busy && tx_valid_in && state == ST_IDLE) begin
                tx_sh   <= tx_byte_in;
                tx_cnt  <= 4'h0;
                tx_busy <= 1'b1;
            end else if (tx_busy && fall_now) begin
                if (tx_cnt >= 4'h8) begin
                    dat_oe_out <= 8'h00;
                    tx_busy    <= 1'b0;
                end else begin
                    dat_oe_out <= (width == `WIDTH_8) ? 8'hff :
                                  (width == `WIDTH_4) ? 8'h0f : 8'h01;
                    dat_line_out <= (width == `WIDTH_8) ? tx_sh :
                                    (width == `WIDTH_4) ? {4'hf, tx_sh[7:4]} :
                                    {7'h7f, tx_sh[7]};
                    tx_sh  <= (width == `WIDTH_8) ? 8'h00 :
                              (width == `WIDTH_4) ? {tx_sh[3:0], 4'h0} :
                              {tx_sh[6:0], 1'b0};
                    tx_cnt <= tx_cnt + step;
                end
            end
        end
    end
endmodule

// ==== sim/card_host_assertions.sv ====
// Port checks for the card bus host controller.
`timescale 1ns/1ns
module card_host_assertions (
    input logic       sys_clk_in,
    input logic       rst_in,
    input logic       boot_hold_in,
    input logic       cmd_valid_in,
    input logic       cmd_push_pull_in,
    input logic [1:0] bus_width_in,
    input logic       rx_ready_in,
    input logic       init_done_out,
    input logic       cmd_ready_out,
    input logic       rx_valid_out,
    input logic [7:0] rx_byte_out,
    input logic       bus_clk_out,
    input logic       cmd_line_out,
    input logic       cmd_oe_out,
    input logic [7:0] dat_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic [6:0] rises;
    // Saturating count of bus clock rises, so a long preamble cannot wrap.
    always_ff @(posedge sys_clk_in or posedge rst_in)
        if (rst_in)
            rises <= 7'h00;
        else if ($rose(bus_clk_out) && rises != 7'h7f)
            rises <= rises + 7'h01;
    a_preamble_long: assert property (
        $rose(init_done_out) |-> rises >= 7'h4a) else $error("preamble too short");
    a_no_early_cmd: assert property (
        !init_done_out && !boot_hold_in |-> !cmd_oe_out) else $error("early command drive");
    a_busy_span: assert property (
        cmd_valid_in && cmd_ready_out |=> !cmd_ready_out [*8] ##[376:386] $rose(cmd_ready_out))
        else $error("command length wrong");
    a_od_low_only: assert property (
        cmd_oe_out && !cmd_push_pull_in |-> !cmd_line_out) else $error("open-drain one driven");
    a_pp_drive: assert property (
        $fell(cmd_ready_out) && cmd_push_pull_in |-> ##[1:9] cmd_oe_out)
        else $error("push-pull command not driven");
    a_oe_on_fall: assert property (
        $changed(cmd_oe_out) && init_done_out && !boot_hold_in && !$past(boot_hold_in, 8)
        |-> $fell(bus_clk_out)) else $error("command bit moved off a fall");
    a_dat_width: assert property (
        (dat_oe_out & ~(bus_width_in == 2'h2 ? 8'hff : bus_width_in == 2'h1 ? 8'h0f : 8'h01))
        == 8'h00) else $error("data line beyond width driven");
    a_clk_half: assert property (
        $rose(bus_clk_out) |=> bus_clk_out [*3] ##1 !bus_clk_out) else $error("bus clock wrong");
    a_rx_hold: assert property (
        rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_byte_out))
        else $error("byte lost in stall");
endmodule
bind card_host card_host_assertions i_card_host_assertions (.sys_clk_in, .rst_in, .boot_hold_in,
    .cmd_valid_in, .cmd_push_pull_in, .bus_width_in, .rx_ready_in, .init_done_out, .cmd_ready_out,
    .rx_valid_out, .rx_byte_out, .bus_clk_out, .cmd_line_out, .cmd_oe_out, .dat_oe_out);

// ==== sim/card_dev_model.sv ====
// Behavioural card: pull-ups on all data lines in 1-bit width, on lines 0 and 3 only in 8-bit, all but 1 and 2 in 4-bit; boot stream on data line 0.
`timescale 1ns/1ns
module card_dev_model #(
    parameter logic [15:0] BOOT_DATA = 16'hc35a
) (
    input  logic       bus_clk_in,
    input  logic       cmd_line_in,
    input  logic       cmd_oe_in,
    input  logic [7:0] dat_line_in,
    input  logic [7:0] dat_oe_in,
    input  logic [1:0] width_in,
    output logic       cmd_wire_out,
    output logic [7:0] dat_wire_out
);
    logic [15:0] boot_sr = BOOT_DATA;
    logic [6:0]  lows = 7'h00;
    logic        flip = 1'b0;
    logic [7:0]  pull;
    logic        drive;
    // Boot data starts after the host's 74-clock low preamble, so the
    // first streamed bit lines up with the host's first boot sample.
    // boot stream
    assign drive = lows >= 7'h4a;
    always @(posedge bus_clk_in) begin
        flip <= ~flip;
        if (cmd_wire_out)
            lows <= 7'h00;
        else if (lows != 7'h7f)
            lows <= lows + 7'h01;
        if (drive)
            boot_sr <= {boot_sr[14:0], boot_sr[15]};
    end
    assign pull = width_in == 2'h1 ? 8'hf9 : width_in == 2'h2 ? 8'h09 : 8'hff;
    assign cmd_wire_out = cmd_oe_in ? cmd_line_in : 1'b1;
    always_comb
        for (int i = 0; i < 8; i++)
            dat_wire_out[i] = dat_oe_in[i] ? dat_line_in[i] :
                (i == 0 && drive) ? boot_sr[15] : pull[i] | flip;
endmodule

// ==== sim/card_host_tb.sv ====
// Self-checking bench for the card bus host controller.
`timescale 1ns/1ns
module card_host_tb;
    typedef struct {logic [47:0] frame; logic pp; logic [1:0] width; logic [7:0] tx;} row_t;
    logic        sys_clk_in, rst_in, supply_ok_in, boot_hold_in, cmd_valid_in, cmd_push_pull_in;
    logic        tx_valid_in, rx_ready_in, cmd_line_in, init_done_out, cmd_ready_out;
    logic        tx_ready_out, rx_valid_out, bus_clk_out, cmd_line_out, cmd_oe_out;
    logic [47:0] cmd_frame_in, seen;
    logic [1:0]  bus_width_in;
    logic [7:0]  tx_byte_in, dat_line_in, rx_byte_out, dat_line_out, dat_oe_out, tx_seen;
    int          err_count, checks, cycles;
    row_t rows [0:4] = '{'{48'h4000_0000_0095, 1'b0, 2'h0, 8'h81},
        '{48'h400f_ffff_fa01, 1'b0, 2'h1, 8'h3c}, '{48'h4100_ff80_0001, 1'b0, 2'h2, 8'he7},
        '{48'h4712_3400_0001, 1'b1, 2'h2, 8'h5a}, '{48'h4d12_3400_00ff, 1'b1, 2'h0, 8'h0f}};
    card_host #(.INIT_CYCLES(20)) i_card_host (.sys_clk_in, .rst_in, .supply_ok_in,
        .boot_hold_in, .cmd_valid_in, .cmd_frame_in, .cmd_push_pull_in, .bus_width_in,
        .tx_valid_in, .tx_byte_in, .rx_ready_in, .cmd_line_in, .dat_line_in, .init_done_out,
        .cmd_ready_out, .tx_ready_out, .rx_valid_out, .rx_byte_out, .bus_clk_out,
        .cmd_line_out, .cmd_oe_out, .dat_line_out, .dat_oe_out);
    card_dev_model i_card_dev_model (.bus_clk_in(bus_clk_out), .cmd_line_in(cmd_line_out),
        .cmd_oe_in(cmd_oe_out), .dat_line_in(dat_line_out), .dat_oe_in(dat_oe_out),
        .width_in(bus_width_in), .cmd_wire_out(cmd_line_in), .dat_wire_out(dat_line_in));
    task automatic check_frame(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected frame at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected byte at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("err_count %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    // The far side samples the command line on each bus clock rise while cmd_ready_out is low.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 12000) begin
            err_count++;
            end_of_test();
        end
        if ($rose(bus_clk_out) && !cmd_ready_out)
            seen <= {seen[46:0], cmd_line_in};
        if ($rose(bus_clk_out) && dat_oe_out[0])
            tx_seen <= dat_oe_out[7] ? dat_line_in : dat_oe_out[3] ?
                {tx_seen[3:0], dat_line_in[3:0]} : {tx_seen[6:0], dat_line_in[0]};
    end
    initial begin
        {rst_in, supply_ok_in, boot_hold_in, cmd_valid_in, cmd_push_pull_in} = 5'h10;
        {tx_valid_in, rx_ready_in, bus_width_in, cmd_frame_in, tx_byte_in} = '0;
        repeat (20) @(posedge sys_clk_in);
        check_byte({cmd_line_out, cmd_oe_out, bus_clk_out, init_done_out, cmd_ready_out,
            tx_ready_out, rx_valid_out, 1'b0}, 8'h80);
        check_byte(dat_line_out & ~dat_oe_out, 8'hff);
        rst_in <= 1'b0;
        repeat (10) @(posedge sys_clk_in);
        supply_ok_in <= 1'b1;
        while (cmd_ready_out !== 1'b1) @(posedge sys_clk_in);
        foreach (rows[r]) begin
            bus_width_in <= rows[r].width;
            cmd_push_pull_in <= rows[r].pp;
            tx_byte_in <= rows[r].tx;
            tx_valid_in <= 1'b1;
            @(posedge sys_clk_in);
            while (tx_ready_out !== 1'b1) @(posedge sys_clk_in);
            tx_valid_in <= 1'b0;
            // Ten bus clocks let a whole byte leave before the width may change.
            repeat (80) @(posedge sys_clk_in);
            check_byte(tx_seen, rows[r].tx);
            cmd_frame_in <= rows[r].frame;
            cmd_valid_in <= 1'b1;
            @(posedge sys_clk_in);
            while (cmd_ready_out !== 1'b1) @(posedge sys_clk_in);
            cmd_valid_in <= 1'b0;
            @(posedge sys_clk_in);
            while (cmd_ready_out !== 1'b1) @(posedge sys_clk_in);
            check_frame(seen, rows[r].frame);
        end
        cmd_push_pull_in <= 1'b0;
        boot_hold_in <= 1'b1;
        // Boot entry needs a fresh power-on with the command line held low.
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        check_byte({cmd_line_out, cmd_oe_out, bus_clk_out, init_done_out, cmd_ready_out,
            tx_ready_out, rx_valid_out, 1'b0}, 8'h80);
        rst_in <= 1'b0;
        while (rx_valid_out !== 1'b1) @(posedge sys_clk_in);
        // Stall long enough for the buffer to fill and overflow.
        repeat (300) @(posedge sys_clk_in);
        for (int k = 0; k < 2; k++) begin
            rx_ready_in <= 1'b1;
            @(posedge sys_clk_in);
            while (rx_valid_out !== 1'b1) @(posedge sys_clk_in);
            check_byte(rx_byte_out, k == 0 ? 8'hc3 : 8'h5a);
            rx_ready_in <= 1'b0;
            @(posedge sys_clk_in);
        end
        boot_hold_in <= 1'b0;
        end_of_test();
    end
endmodule
